// file: shared/bsg_params.svh
// Register offsets, field positions, reset values and clock figures of the tone generator.
`ifndef BSG_PARAMS_SVH
`define BSG_PARAMS_SVH

// Register offsets on the plain register port.
`define BSG_OFF_TONE_DIV 4'h0
`define BSG_OFF_PORT0_FUNC 4'h1
`define BSG_OFF_CLK_SRC 4'h2
`define BSG_OFF_STATUS 4'h3
`define BSG_OFF_COUNT 4'h4

// Field positions inside the tone divider register.
`define BSG_MATCH_LSB 0
`define BSG_MATCH_MSB 5
`define BSG_SEL_LSB 6
`define BSG_SEL_MSB 7

// Tone pin enable bit inside the port function register.
`define BSG_PIN_EN_BIT 4

// Source select bit inside the clock source register.
`define BSG_SRC_SUB_BIT 0

// Status register bits.
`define BSG_STAT_TONE_BIT 0
`define BSG_STAT_SRC_BIT 1

// Reset values.
`define BSG_MATCH_RST 6'h3f
`define BSG_SEL_RST 2'h0

// Prescaler base ratio for select code 00; each code step doubles it.
`define BSG_PRESCALE_BASE 8'h08

// Extra divide applied to sub-clock edges.
`define BSG_SUB_DIV 8'h80

// Clock rate figures.
`define BSG_CLK_MHZ 50
`define BSG_CLK_PERIOD_NS 20

`endif

// file: shared/bsg_pkg.sv
// Types shared by the tone generator modules.
`default_nettype none

package bsg_pkg;

    // State of the tick divider.
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } bsg_div_state_t;

    // State of the pin synchroniser.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } bsg_sync_state_t;

    // State of the tone generator top.
    typedef struct packed {
        logic [5:0] match;
        logic [1:0] sel;
        logic pin_en;
        logic src_sub;
        logic [5:0] cnt;
        logic tone;
        logic pin;
        logic [7:0] rdata;
    } bsg_top_state_t;

endpackage

`default_nettype wire

// file: rtl/bsg_pin_sync.sv
// Three-stage synchroniser with rising edge detection for an outside pin.
`timescale 1ns/1ns
`default_nettype none

module bsg_pin_sync (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic rise_o
);
    import bsg_pkg::*;

    bsg_sync_state_t st_q;
    bsg_sync_state_t st_d;

    // The first stage feeds only the second; the level moves once the last two agree.
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.rise = 1'b0;
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
            st_d.rise = st_q.s3 & ~st_q.level;
        end
    end

    // State register.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise_o = st_q.rise;
endmodule

`default_nettype wire

// file: rtl/bsg_tick_div.sv
// Divider that passes one tick out of every ratio ticks in.
`timescale 1ns/1ns
`default_nettype none

module bsg_tick_div (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [7:0] ratio_i,
    output logic tick_o
);
    import bsg_pkg::*;

    bsg_div_state_t st_q;
    bsg_div_state_t st_d;

    // Count input ticks; the last one of each group of ratio ticks goes out.
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (clear_i) begin
            st_d.cnt = 8'h00;
        end else if (tick_i) begin
            if (st_q.cnt >= ratio_i - 8'h01) begin
                st_d.cnt = 8'h00;
                st_d.tick = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 8'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;
endmodule

`default_nettype wire

// file: rtl/bsg_tone_gen.sv
// Programmable square wave tone generator with its register port.
//
// Behaviour
// R1: Tone generator is a 6-bit up-counter, a control register and clock selector.
// R2: Any write to the tone divider register clears the counter to zero.
// R3: Counter steps on each selected source tick until it equals the match value.
// R4: On match the counter clears and the tone output toggles, 50% duty.
// R5: Divider bits 5:0 hold the match value, reset value 3f hex.
// R6: Tone divider register is write-only and reads back as zero.
// R7: Divider bits 7:6 choose the prescaler output clocking the counter.
// R8: Tone frequency is clock over twice prescale ratio times match plus one.
// R9: Select codes give ratios 8, 16, 32, 64; each code halves the tone.
// R10: Sub-clock source adds a further divide by 128 to the tone frequency.
// R11: Software sets the pin enable bit so the shared pin carries the tone.
// R12: Tone flop is low after reset and cleared by each divider write.
`timescale 1ns/1ns
`default_nettype none
`include "bsg_params.svh"

module bsg_tone_gen (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [7:0] rdata_o,
    input wire logic sub_clock_i,
    input wire logic gpio_bit4_i,
    output logic tone_o,
    output logic port0_bit4_pin_o
);
    import bsg_pkg::*;

    bsg_top_state_t st_q;
    bsg_top_state_t st_d;

    logic wr_tone_div;
    logic wr_port0_func;
    logic wr_clk_src;
    logic sub_rise;
    logic sub_tick;
    logic src_tick;
    logic pre_tick;
    logic [7:0] pre_ratio;

    // Write decode; a divider write also restarts every divider in the chain.
    assign wr_tone_div = write_i && (addr_i == `BSG_OFF_TONE_DIV);
    assign wr_port0_func = write_i && (addr_i == `BSG_OFF_PORT0_FUNC);
    assign wr_clk_src = write_i && (addr_i == `BSG_OFF_CLK_SRC);

    // The sub-clock arrives from its own oscillator, so it is only sampled here.
    bsg_pin_sync u_sub_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .pin_i(sub_clock_i),
        .rise_o(sub_rise)
    );

    // Sub-clock edges are divided by 128 before they reach the prescaler.
    bsg_tick_div u_sub_div (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .clear_i(wr_tone_div),
        .tick_i(sub_rise),
        .ratio_i(`BSG_SUB_DIV), // R10
        .tick_o(sub_tick)
    );

    // Clock selector: every main clock cycle, or the divided sub-clock.
    assign src_tick = st_q.src_sub ? sub_tick : 1'b1; // R1

    // Prescaler ratio doubles with each select code step.
    assign pre_ratio = `BSG_PRESCALE_BASE << st_q.sel; // R7 R9

    // Prescaler whose output clocks the 6-bit counter.
    bsg_tick_div u_prescale (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .clear_i(wr_tone_div),
        .tick_i(src_tick),
        .ratio_i(pre_ratio),
        .tick_o(pre_tick)
    );

    // Next state: register writes, counting, toggling, pin mux and read data.
    always_comb begin
        st_d = st_q;
        st_d.rdata = 8'h00;

        // Divider write stores the fields and restarts from a known phase.
        if (wr_tone_div) begin
            st_d.match = wdata_i[`BSG_MATCH_MSB:`BSG_MATCH_LSB]; // R5
            st_d.sel = wdata_i[`BSG_SEL_MSB:`BSG_SEL_LSB]; // R7
            st_d.cnt = 6'h00; // R2
            st_d.tone = 1'b0; // R12
        end else if (pre_tick) begin
            // Half period is match plus one prescaled ticks.
            if (st_q.cnt == st_q.match) begin
                st_d.cnt = 6'h00; // R4
                st_d.tone = ~st_q.tone; // R4 R8
            end else begin
                st_d.cnt = st_q.cnt + 6'h01; // R3
            end
        end

        // Port function register holds only the tone pin enable bit.
        if (wr_port0_func) begin
            st_d.pin_en = wdata_i[`BSG_PIN_EN_BIT];
        end

        // Clock source register chooses main clock or sub-clock.
        if (wr_clk_src) begin
            st_d.src_sub = wdata_i[`BSG_SRC_SUB_BIT];
        end

        // The pin carries the tone only while software has enabled it.
        st_d.pin = st_d.pin_en ? st_d.tone : gpio_bit4_i; // R11

        // Read data stand only in the cycle after the read strobe.
        if (read_i) begin
            case (addr_i)
                `BSG_OFF_TONE_DIV: begin
                    st_d.rdata = 8'h00; // R6
                end
                `BSG_OFF_PORT0_FUNC: begin
                    st_d.rdata[`BSG_PIN_EN_BIT] = st_q.pin_en;
                end
                `BSG_OFF_CLK_SRC: begin
                    st_d.rdata[`BSG_SRC_SUB_BIT] = st_q.src_sub;
                end
                `BSG_OFF_STATUS: begin
                    st_d.rdata[`BSG_STAT_TONE_BIT] = st_q.tone;
                    st_d.rdata[`BSG_STAT_SRC_BIT] = st_q.src_sub;
                end
                `BSG_OFF_COUNT: begin
                    st_d.rdata = {2'h0, st_q.cnt};
                end
                default: begin
                    st_d.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register; reset leaves the tone low and the match at its top value.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_q <= '0;
            st_q.match <= `BSG_MATCH_RST; // R5
            st_q.sel <= `BSG_SEL_RST;
            st_q.tone <= 1'b0; // R12
        end else begin
            st_q <= st_d;
        end
    end

    // All outputs come straight from the state register.
    assign rdata_o = st_q.rdata;
    assign tone_o = st_q.tone;
    assign port0_bit4_pin_o = st_q.pin;
endmodule

`default_nettype wire

// file: testbench/bsg_buzzer_model.sv
// Buzzer model on the tone pin: counts pin edges and times each half wave.
`timescale 1ns/1ns
`default_nettype none

module bsg_buzzer_model (
    input wire logic clock_i,
    input wire logic pin_i,
    output int edges_o,
    output int half_o
);
    logic last_q = 1'b0;
    int run_q = 0;

    // A buzzer only listens, so it measures how many clocks each level lasts.
    always @(posedge clock_i) begin
        last_q <= pin_i;
        run_q <= (pin_i != last_q) ? 1 : run_q + 1;
        if (pin_i != last_q) begin
            edges_o <= edges_o + 1;
            half_o <= run_q;
        end
    end
endmodule

`default_nettype wire

// file: testbench/bsg_tone_gen_chk.sv
// Port checker for the tone generator, bound to its top module.
`timescale 1ns/1ns
`default_nettype none

module bsg_tone_gen_chk (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [7:0] rdata_o,
    input wire logic sub_clock_i,
    input wire logic gpio_bit4_i,
    input wire logic tone_o,
    input wire logic port0_bit4_pin_o
);
    logic [7:0] div_q;
    logic en_q;
    logic src_q;
    logic tg_q;
    logic [15:0] gap_q;
    logic [15:0] half;

    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // Shadow the settings, since the divider cannot be read back.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            div_q <= 8'h3f;
            en_q <= 1'b0;
            src_q <= 1'b0;
        end else if (write_i) begin
            if (addr_i == 4'h0) div_q <= wdata_i;
            if (addr_i == 4'h1) en_q <= wdata_i[4];
            if (addr_i == 4'h2) src_q <= wdata_i[0];
        end
    end

    // Time each half wave; any write spoils the phase, so the next one is not judged.
    always_ff @(posedge clock_i) begin
        if (reset_i || write_i) begin
            tg_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            // A change forced by a divider write is not a half wave, so it must not arm the check.
            tg_q <= tg_q | ($changed(tone_o) && !$past(write_i));
            gap_q <= $changed(tone_o) ? 16'h0001 : gap_q + 16'h0001;
        end
    end

    assign half = (16'h0008 << div_q[7:6]) * (16'(div_q[5:0]) + 16'h0001);

    a_half_period: assert property ($changed(tone_o) && tg_q && !src_q |-> gap_q == half)
        else $error("tone half period wrong");
    a_sub_slow: assert property ($changed(tone_o) && tg_q && src_q |-> gap_q > 16'h03e8)
        else $error("sub-clock tone too fast");
    a_write_restart: assert property (write_i && addr_i == 4'h0 |=> !tone_o [*7])
        else $error("tone not restarted by divider write");
    a_div_reads_zero: assert property (read_i && addr_i == 4'h0 |=> rdata_o == 8'h00)
        else $error("divider register readable");
    a_rdata_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    a_count_width: assert property (read_i && addr_i == 4'h4 |=> rdata_o[7:6] == 2'h0)
        else $error("counter wider than six bits");
    a_pin_tone: assert property (en_q |-> port0_bit4_pin_o == tone_o)
        else $error("pin does not carry tone");
    a_pin_gpio: assert property (!en_q && !$past(reset_i) |-> port0_bit4_pin_o == $past(gpio_bit4_i))
        else $error("pin does not carry port data");
    a_reset_quiet: assert property ($fell(reset_i) |-> !tone_o && !port0_bit4_pin_o)
        else $error("tone high after reset");

    c_toggle: cover property ($changed(tone_o) && tg_q && !src_q);
    c_sub_toggle: cover property ($changed(tone_o) && tg_q && src_q);
    c_pin_high: cover property (en_q && tone_o);
endmodule

bind bsg_tone_gen bsg_tone_gen_chk chk_u (.clock_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i,
    .rdata_o, .sub_clock_i, .gpio_bit4_i, .tone_o, .port0_bit4_pin_o);

`default_nettype wire

// file: testbench/bsg_tone_gen_tb_top.sv
// Self-checking bench for the tone generator.
`timescale 1ns/1ns
`default_nettype none

module bsg_tone_gen_tb_top;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic sub_clock_i = 1'b0;
    logic gpio_bit4_i = 1'b0;
    logic [7:0] rdata_o;
    logic tone_o;
    logic port0_bit4_pin_o;
    int error_cnt = 0;
    int checks = 0;
    int edges;
    int half;
    logic [7:0] tbl [4] = '{8'h00, 8'h41, 8'h82, 8'hff};
    // Half periods in clocks for the settings above: ratio 8, 16, 32, 64 times match plus one.
    logic [15:0] exp_half [4] = '{16'h0008, 16'h0020, 16'h0060, 16'h1000};

    bsg_tone_gen dut_u (.clock_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o,
        .sub_clock_i, .gpio_bit4_i, .tone_o, .port0_bit4_pin_o);
    bsg_buzzer_model buzz_u (.clock_i, .pin_i(port0_bit4_pin_o), .edges_o(edges), .half_o(half));

    // Main clock at 50 MHz.
    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // Sub-clock at an odd period so its edges drift against the main clock.
    initial begin
        forever #55 sub_clock_i = ~sub_clock_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        write_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        read_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // The first half after a write may be cut short, so three edges give one clean half.
    task automatic wait_edges(input int n);
        int e0;
        e0 = edges;
        for (int i = 0; i < 20000 && edges < e0 + n; i++) @(posedge clock_i);
        chk(16'(edges - e0 >= n), 16'h0001);
    endtask

    task final_report;
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog sized well above the longest tone period times three.
    initial begin
        repeat (80000) @(posedge clock_i);
        error_cnt++;
        final_report();
    end

    initial begin
        logic [7:0] d;
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(4'h0, d);
        chk(16'(d), 16'h0000);
        rd(4'hf, d);
        chk(16'(d), 16'h0000);
        wr(4'h1, 8'h10);
        wait_edges(3);
        chk(16'(half), 16'h0200);
        foreach (tbl[i]) begin
            wr(4'h0, tbl[i]);
            rd(4'h4, d);
            chk(16'(d), 16'h0000);
            rd(4'h3, d);
            chk(16'(d), 16'h0000);
            wait_edges(3);
            chk(16'(half), exp_half[i]);
        end
        wr(4'h1, 8'h00);
        gpio_bit4_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk(16'(port0_bit4_pin_o), 16'h0001);
        wr(4'h2, 8'h01);
        rd(4'h2, d);
        chk(16'(d), 16'h0001);
        wr(4'h1, 8'h10);
        rd(4'h1, d);
        chk(16'(d), 16'h0010);
        wr(4'h0, 8'h00);
        rd(4'h3, d);
        chk(16'(d), 16'h0002);
        wait_edges(3);
        chk(16'(half > 5629 && half < 5635), 16'h0001);
        final_report();
    end
endmodule

`default_nettype wire
